// file: ufc_feature_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Polarity bit swaps direction pin levels.
// - Transmitter drives direction pin only when enabled.
// - Transmitter disable bit turns transmitter off.
// - Receiver disable bit, independent of transmitter.
// - Mode bit selects RS-232 or multidrop.
// - Level wake refuses sleep while RX low.
// - Level wake: wake when RX goes low.
// - Edge wake: sleep allowed with RX low.
// - Edge wake: wake on any RX toggle.
// - Remap moves flow control to DTR/DSR.
// - Writing soft reset bit resets the UART.
// - Soft reset bit clears itself afterwards.
// - Soft reset lasts four clock cycles.
// - Mode clear: empty or below-trigger interrupt.
// - Mode set: empty also waits for stop.
// - Turnaround delay counted in bits before receive.
// - Soft reset equals hardware reset for registers.
module ufc_feature_ctrl
	import ufc_pkg::*;
#(
	parameter int SOFT_RESET_TRIGGER_CYCLES = SRST_CYCLES
)
(
	// Clock and reset.
	input  wire logic       CORE_CLK,
	input  wire logic       RESET,
	// Register port.
	input  wire logic       REG_CS,
	input  wire logic [1:0] REG_ADDR,
	input  wire logic       REG_WR,
	input  wire logic       REG_RD,
	input  wire logic [7:0] REG_WDATA,
	output logic      [7:0] REG_RDATA,
	// Transmit path status from the UART core.
	input  wire logic       BIT_TICK,
	input  wire logic       TX_FIFO_EMPTY,
	input  wire logic       TX_BELOW_TRIG,
	input  wire logic       TX_SHIFT_BUSY,
	// Sleep request and serial receive pin.
	input  wire logic       SLEEP_REQ,
	input  wire logic       RX_PIN,
	// Modem and flow control.
	input  wire logic       FLOW_ENABLE,
	input  wire logic       FLOW_RX_READY,
	input  wire logic       MCR_RTS,
	input  wire logic       MCR_DTR,
	input  wire logic       CTS_N_PIN,
	input  wire logic       DSR_N_PIN,
	output logic            RTS_N_PIN,
	output logic            DTR_N_PIN,
	output logic            FLOW_CTS_OK,
	output logic            MODEM_CTS,
	output logic            MODEM_DSR,
	// Core controls.
	output logic            TX_ENABLE,
	output logic            RX_ENABLE,
	output logic            MULTIDROP,
	output logic            SLEEPING,
	output logic            TX_EMPTY_IRQ,
	output logic            CORE_RESET
);

	// ------------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------------
	generate
		if (SOFT_RESET_TRIGGER_CYCLES < 1 || SOFT_RESET_TRIGGER_CYCLES > 7) begin : g_bad_param
			$error("SOFT_RESET_TRIGGER_CYCLES must lie in 1..7");
		end
	endgenerate

	localparam logic [2:0] SRST_LOAD = 3'(SOFT_RESET_TRIGGER_CYCLES);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] lfc;
		logic [7:0] mfc;
		logic [7:0] delay;
		logic [2:0] srst_cnt;
		logic       rx_s1;
		logic       rx_s2;
		logic       rx_prev;
		logic       cts_s1;
		logic       cts_s2;
		logic       dsr_s1;
		logic       dsr_s2;
		ufc_sleep_t sleep;
		logic [7:0] rdata;
		logic       rts_n;
		logic       dtr_n;
		logic       cts_ok;
		logic       mcts;      // Status copies, registered so that the
		logic       mdsr;      // outputs come straight from flip-flops.
		logic       tx_en;
		logic       rx_en;
		logic       mdrop;
		logic       irq;
		logic       core_rst;
	} ufc_state_t;

	ufc_state_t st;
	ufc_state_t next_st;

	ufc_turn_if turn ();

	// ------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------

	// Level of the direction pin for the drive state and polarity.
	function automatic logic dir_level(input logic drive,
		input logic inv);
		dir_level = inv ? drive : ~drive;
	endfunction

	// Register read value; unmapped indices read zero.
	function automatic logic [7:0] read_mux(input logic [1:0] addr,
		input ufc_state_t s);
		case (addr)
			LINE_FC_ADDR:  read_mux = s.lfc & LFC_MASK;
			MISC_FC_ADDR:  read_mux = s.mfc & MFC_MASK;
			TURN_DLY_ADDR: read_mux = s.delay;
			default:       read_mux = 8'h00;
		endcase
	endfunction

	// ------------------------------------------------------------------
	// Turnaround counter link
	// ------------------------------------------------------------------

	// In multidrop mode, transmission counts as active while data waits or bits shift out.
	assign turn.tx_active = st.mdrop & (TX_SHIFT_BUSY | ~TX_FIFO_EMPTY);
	assign turn.bit_tick  = BIT_TICK;
	assign turn.delay     = st.delay;

	// The counter restarts with every reset, soft or hard.
	ufc_turnaround u_turn (
		.clk  (CORE_CLK),
		.rst  (RESET | st.core_rst),
		.turn (turn)
	);

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		logic rts_assert;
		logic dtr_assert;
		logic dir_pin;
		logic empty_ok;
		rts_assert = 1'b0;
		dtr_assert = 1'b0;
		dir_pin    = 1'b0;
		empty_ok   = 1'b0;
		next_st    = st;

		// Pin synchronisers; logic reads the second stage, and the receive edge check also reads rx_prev behind it.
		next_st.rx_s1   = RX_PIN;
		next_st.rx_s2   = st.rx_s1;
		next_st.rx_prev = st.rx_s2;
		next_st.cts_s1  = CTS_N_PIN;
		next_st.cts_s2  = st.cts_s1;
		next_st.dsr_s1  = DSR_N_PIN;
		next_st.dsr_s2  = st.dsr_s1;

		// Soft reset: registers held at reset values while the count
		// runs, and the trigger bit reads one until it ends.
		if (st.srst_cnt != 3'h0) begin
			next_st.srst_cnt = st.srst_cnt - 3'h1;
			next_st.lfc      = LFC_RESET;
			next_st.delay    = TURN_DLY_RESET;
			next_st.mfc      = MFC_RESET;
			if (st.srst_cnt != 3'h1) begin
				next_st.mfc[MFC_SOFT_RST] = 1'b1;
			end
			next_st.core_rst = (st.srst_cnt != 3'h1);
			next_st.sleep    = UFC_AWAKE;
		end else if (REG_CS && REG_WR) begin
			// Register writes; reserved bits never store.
			case (REG_ADDR)
				LINE_FC_ADDR: begin
					next_st.lfc = REG_WDATA & LFC_MASK;
				end
				MISC_FC_ADDR: begin
					next_st.mfc = REG_WDATA & MFC_MASK;
					if (REG_WDATA[MFC_SOFT_RST]) begin
						next_st.srst_cnt = SRST_LOAD;
						next_st.core_rst = 1'b1;
					end
				end
				TURN_DLY_ADDR: begin
					next_st.delay = REG_WDATA;
				end
				default: begin
					next_st.lfc = st.lfc;
				end
			endcase
		end

		// Read data is captured on the read strobe and then held.
		if (REG_CS && REG_RD) begin
			next_st.rdata = read_mux(REG_ADDR, st);
		end

		// Mode and enables.
		next_st.mdrop = st.lfc[LFC_MULTIDROP];
		next_st.tx_en = ~st.lfc[LFC_TX_OFF];
		next_st.rx_en = ~st.lfc[LFC_RX_OFF];

		// Sleep entry and wake-up on the receive pin.
		case (st.sleep)
			UFC_AWAKE: begin
				if (SLEEP_REQ) begin
					if (st.mfc[MFC_EDGE_SEL]) begin
						next_st.sleep = UFC_ASLEEP;
					end else if (st.rx_s2) begin
						next_st.sleep = UFC_ASLEEP;
					end
				end
			end
			UFC_ASLEEP: begin
				if (!SLEEP_REQ) begin
					next_st.sleep = UFC_AWAKE;
				end else if (st.mfc[MFC_EDGE_SEL]) begin
					if (st.rx_s2 != st.rx_prev) begin
						next_st.sleep = UFC_AWAKE;
					end
				end else if (!st.rx_s2) begin
					next_st.sleep = UFC_AWAKE;
				end
			end
			default: begin
				next_st.sleep = UFC_AWAKE;
			end
		endcase

		// Hardware flow control goes to one pin pair; the other pair
		// keeps its plain modem function from the control register.
		if (st.mfc[MFC_REMAP]) begin
			rts_assert = MCR_RTS;
			dtr_assert = FLOW_ENABLE ? FLOW_RX_READY : MCR_DTR;
			next_st.cts_ok = ~st.dsr_s2 | ~FLOW_ENABLE;
		end else begin
			rts_assert = FLOW_ENABLE ? FLOW_RX_READY : MCR_RTS;
			dtr_assert = MCR_DTR;
			next_st.cts_ok = ~st.cts_s2 | ~FLOW_ENABLE;
		end
		next_st.rts_n = ~rts_assert;
		next_st.dtr_n = ~dtr_assert;

		// Modem status always reports the synchronised input pins.
		next_st.mcts = ~st.cts_s2;
		next_st.mdsr = ~st.dsr_s2;

		// Direction control overrides the selected pin in multidrop when its transmit control bit is set.
		dir_pin = dir_level(turn.drive_tx, st.lfc[LFC_POL_INV]);
		if (st.lfc[LFC_MULTIDROP] && st.lfc[LFC_TX_CTL]) begin
			if (st.lfc[LFC_PIN_SEL]) begin
				next_st.dtr_n = dir_pin;
			end else begin
				next_st.rts_n = dir_pin;
			end
		end

		// Transmit-empty interrupt condition.
		if (st.mfc[MFC_IRQ_MODE]) begin
			empty_ok = TX_FIFO_EMPTY & ~TX_SHIFT_BUSY;
		end else begin
			empty_ok = TX_FIFO_EMPTY;
		end
		next_st.irq = TX_BELOW_TRIG | empty_ok;
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------

	// Hardware reset sets the same values the soft reset holds.
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			st <= '{
				lfc:      LFC_RESET,
				mfc:      MFC_RESET,
				delay:    TURN_DLY_RESET,
				srst_cnt: 3'h0,
				rx_s1:    1'b1,
				rx_s2:    1'b1,
				rx_prev:  1'b1,
				cts_s1:   1'b1,
				cts_s2:   1'b1,
				dsr_s1:   1'b1,
				dsr_s2:   1'b1,
				sleep:    UFC_AWAKE,
				rdata:    8'h00,
				rts_n:    1'b1,
				dtr_n:    1'b1,
				cts_ok:   1'b0,
				mcts:     1'b0,
				mdsr:     1'b0,
				tx_en:    1'b1,
				rx_en:    1'b1,
				mdrop:    1'b0,
				irq:      1'b0,
				core_rst: 1'b0
			};
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------------
	// Outputs, all straight from the state register
	// ------------------------------------------------------------------
	assign REG_RDATA    = st.rdata;
	assign RTS_N_PIN    = st.rts_n;
	assign DTR_N_PIN    = st.dtr_n;
	assign FLOW_CTS_OK  = st.cts_ok;
	assign MODEM_CTS    = st.mcts;
	assign MODEM_DSR    = st.mdsr;
	assign TX_ENABLE    = st.tx_en;
	assign RX_ENABLE    = st.rx_en;
	assign MULTIDROP    = st.mdrop;
	assign SLEEPING     = (st.sleep == UFC_ASLEEP);
	assign TX_EMPTY_IRQ = st.irq;
	assign CORE_RESET   = st.core_rst;

endmodule
`default_nettype wire

// file: ufc_pkg.sv
`default_nettype none
package ufc_pkg;

	// ------------------------------------------------------------------
	// Register indices on the parallel register port
	// ------------------------------------------------------------------
	localparam logic [1:0] LINE_FC_ADDR  = 2'h0;
	localparam logic [1:0] MISC_FC_ADDR  = 2'h1;
	localparam logic [1:0] TURN_DLY_ADDR = 2'h2;

	// ------------------------------------------------------------------
	// Field positions of line_feature_control
	// ------------------------------------------------------------------
	localparam int LFC_MULTIDROP = 0;
	localparam int LFC_RX_OFF    = 1;
	localparam int LFC_TX_OFF    = 2;
	localparam int LFC_PIN_SEL   = 3;
	localparam int LFC_TX_CTL    = 4;
	localparam int LFC_POL_INV   = 5;
	localparam logic [7:0] LFC_MASK = 8'h3f;

	// ------------------------------------------------------------------
	// Field positions of misc_feature_control
	// ------------------------------------------------------------------
	localparam int MFC_IRQ_MODE = 0;
	localparam int MFC_SOFT_RST = 1;
	localparam int MFC_REMAP    = 2;
	localparam int MFC_EDGE_SEL = 4;
	localparam logic [7:0] MFC_MASK = 8'h17;

	// ------------------------------------------------------------------
	// Reset values and timing counts
	// ------------------------------------------------------------------
	localparam logic [7:0] LFC_RESET      = 8'h00;
	localparam logic [7:0] MFC_RESET      = 8'h00;
	localparam logic [7:0] TURN_DLY_RESET = 8'h00;
	localparam int         SRST_CYCLES    = 4;

	// ------------------------------------------------------------------
	// State encodings
	// ------------------------------------------------------------------
	typedef enum logic [0:0] {
		UFC_AWAKE  = 1'b0,
		UFC_ASLEEP = 1'b1
	} ufc_sleep_t;

	typedef enum logic [1:0] {
		UFC_IDLE = 2'b00,
		UFC_XMIT = 2'b01,
		UFC_HOLD = 2'b10
	} ufc_turn_t;

endpackage
`default_nettype wire

// file: ufc_turn_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ufc_turn_if;
	logic       tx_active;
	logic       bit_tick;
	logic [7:0] delay;
	logic       drive_tx;

	modport ctl (output tx_active, output bit_tick, output delay,
		input drive_tx);
	modport cnt (input tx_active, input bit_tick, input delay,
		output drive_tx);
endinterface
`default_nettype wire

// file: ufc_turnaround.sv
`timescale 1ns/1ps
`default_nettype none
module ufc_turnaround
	import ufc_pkg::*;
(
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst,
	// Link to the control logic.
	ufc_turn_if.cnt   turn
);

	typedef struct packed {
		ufc_turn_t  phase;
		logic [7:0] count;
		logic       drive;
	} ufc_turn_state_t;

	ufc_turn_state_t st;
	ufc_turn_state_t next_st;

	assign turn.drive_tx = st.drive;

	// ------------------------------------------------------------------
	// Direction hold: drive while sending, then count bit times down.
	// ------------------------------------------------------------------
	always_comb begin
		next_st = st;
		case (st.phase)
			UFC_IDLE: begin
				if (turn.tx_active) begin
					next_st.phase = UFC_XMIT;
					next_st.drive = 1'b1;
				end
			end
			UFC_XMIT: begin
				if (!turn.tx_active) begin
					if (turn.delay == 8'h00) begin
						next_st.phase = UFC_IDLE;
						next_st.drive = 1'b0;
					end else begin
						next_st.phase = UFC_HOLD;
						next_st.count = turn.delay;
					end
				end
			end
			UFC_HOLD: begin
				// New data restarts transmission without a turnaround.
				if (turn.tx_active) begin
					next_st.phase = UFC_XMIT;
				end else if (turn.bit_tick) begin
					if (st.count == 8'h01) begin
						next_st.phase = UFC_IDLE;
						next_st.drive = 1'b0;
					end else begin
						next_st.count = st.count - 8'h01;
					end
				end
			end
			default: begin
				next_st.phase = UFC_IDLE;
				next_st.drive = 1'b0;
			end
		endcase
	end

	// Register the state.
	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '{phase: UFC_IDLE, count: 8'h00, drive: 1'b0};
		end else begin
			st <= next_st;
		end
	end

endmodule
`default_nettype wire

// file: ufc_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checker for the feature control
// ----------------------------------------
module ufc_checker
	import ufc_pkg::*;
#(
	parameter int SOFT_RESET_TRIGGER_CYCLES = SRST_CYCLES
)
(
	// Clock and reset.
	input wire logic       CORE_CLK,
	input wire logic       RESET,
	// Register port.
	input wire logic       REG_CS,
	input wire logic [1:0] REG_ADDR,
	input wire logic       REG_WR,
	input wire logic       REG_RD,
	input wire logic [7:0] REG_WDATA,
	input wire logic [7:0] REG_RDATA,
	// Transmit status.
	input wire logic       TX_FIFO_EMPTY,
	input wire logic       TX_BELOW_TRIG,
	input wire logic       TX_SHIFT_BUSY,
	// Pins and core controls.
	input wire logic       RTS_N_PIN,
	input wire logic       DTR_N_PIN,
	input wire logic       TX_ENABLE,
	input wire logic       RX_ENABLE,
	input wire logic       MULTIDROP,
	input wire logic       SLEEPING,
	input wire logic       TX_EMPTY_IRQ,
	input wire logic       CORE_RESET
);
	typedef struct packed {
		logic [7:0] lfc;
		logic       irqm;
		logic [2:0] hi;
	} ufc_shadow_t;
	ufc_shadow_t s;
	ufc_shadow_t next_s;
	logic        wr_ok;
	logic        trig;
	logic        dir_on;

	// Writes seen while the core sits in soft reset are dropped.
	assign wr_ok  = REG_CS && REG_WR && !CORE_RESET;
	assign trig   = wr_ok && REG_ADDR == MISC_FC_ADDR
		&& REG_WDATA[MFC_SOFT_RST];
	assign dir_on = s.lfc[LFC_MULTIDROP] && s.lfc[LFC_TX_CTL];

	// Shadow registers and the length of the soft reset pulse.
	always_comb begin
		next_s = s;
		next_s.hi = CORE_RESET ? s.hi + 3'h1 : 3'h0;
		if (wr_ok && REG_ADDR == LINE_FC_ADDR)
			next_s.lfc = REG_WDATA & LFC_MASK;
		if (wr_ok && REG_ADDR == MISC_FC_ADDR)
			next_s.irqm = REG_WDATA[MFC_IRQ_MODE];
		// The registers sit at reset values for every cycle of the count.
		if (CORE_RESET) begin
			next_s.lfc = LFC_RESET;
			next_s.irqm = MFC_RESET[MFC_IRQ_MODE];
		end
	end

	// Shadow state register.
	always_ff @(posedge CORE_CLK) begin
		if (RESET)
			s <= '0;
		else
			s <= next_s;
	end

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RESET);

	tx_off_a: assert property (!$past(RESET) && !$past(trig) |->
		TX_ENABLE == !$past(s.lfc[LFC_TX_OFF])) else $error("tx enable");
	rx_off_a: assert property (!$past(RESET) && !$past(trig) |->
		RX_ENABLE == !$past(s.lfc[LFC_RX_OFF])) else $error("rx enable");
	mode_copy_a: assert property (!$past(RESET) && !$past(trig) |->
		MULTIDROP == $past(s.lfc[LFC_MULTIDROP])) else $error("mode");
	irq_mode_a: assert property (
		!$past(RESET) && !$past(CORE_RESET) |-> TX_EMPTY_IRQ ==
		$past(TX_BELOW_TRIG || TX_FIFO_EMPTY
		&& (!TX_SHIFT_BUSY || !s.irqm))) else $error("tx empty irq");
	dir_level_a: assert property (
		(dir_on && !TX_FIFO_EMPTY && !CORE_RESET && $stable(s.lfc))[*5]
		|-> (s.lfc[LFC_PIN_SEL] ? DTR_N_PIN : RTS_N_PIN)
		== s.lfc[LFC_POL_INV]) else $error("direction level");
	rd_line_a: assert property (!$past(RESET) && $past(REG_CS && REG_RD
		&& REG_ADDR == LINE_FC_ADDR) |-> REG_RDATA == $past(s.lfc))
		else $error("line readback");
	rsvd_misc_a: assert property ($past(REG_CS && REG_RD
		&& REG_ADDR == MISC_FC_ADDR) |-> (REG_RDATA & ~MFC_MASK) == 8'h00)
		else $error("misc");
	srst_start_a: assert property (trig |=> CORE_RESET)
		else $error("soft reset start");
	srst_len_a: assert property (
		$fell(CORE_RESET) |-> s.hi == SOFT_RESET_TRIGGER_CYCLES)
		else $error("soft reset length");

	cover property (trig);
	cover property (dir_on && !TX_FIFO_EMPTY);
	cover property ($rose(SLEEPING));
endmodule

bind ufc_feature_ctrl ufc_checker #(.SOFT_RESET_TRIGGER_CYCLES(SOFT_RESET_TRIGGER_CYCLES)) u_chk (
	.CORE_CLK(CORE_CLK), .RESET(RESET), .REG_CS(REG_CS),
	.REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
	.REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
	.TX_FIFO_EMPTY(TX_FIFO_EMPTY), .TX_BELOW_TRIG(TX_BELOW_TRIG),
	.TX_SHIFT_BUSY(TX_SHIFT_BUSY), .RTS_N_PIN(RTS_N_PIN),
	.DTR_N_PIN(DTR_N_PIN), .TX_ENABLE(TX_ENABLE), .RX_ENABLE(RX_ENABLE),
	.MULTIDROP(MULTIDROP), .SLEEPING(SLEEPING),
	.TX_EMPTY_IRQ(TX_EMPTY_IRQ), .CORE_RESET(CORE_RESET));
`default_nettype wire

// file: ufc_line_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Serial line and transceiver peer
// ----------------------------------------
module ufc_line_model (
	// Clock and commands.
	input  wire logic       clk,
	input  wire logic       line_low,
	input  wire logic [1:0] peer_ready,
	// Pins towards the block.
	output logic            rx_line,
	output logic            cts_n,
	output logic            dsr_n
);
	// Peer pins follow the commands one falling edge later, off the
	// sampling edge; the idle command leaves the line high, as on its
	// pull-up, and the block's reset covers the first whole cycle.
	always @(negedge clk) begin
		rx_line <= !line_low;
		cts_n <= !peer_ready[0];
		dsr_n <= !peer_ready[1];
	end
endmodule
`default_nettype wire

// file: tb_ufc_feature_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ufc_feature_ctrl
	import ufc_pkg::*;
;
	logic       CORE_CLK, RESET, REG_CS, REG_WR, REG_RD, BIT_TICK;
	logic [1:0] REG_ADDR, peer_ready;
	logic [7:0] REG_WDATA, REG_RDATA;
	logic       TX_FIFO_EMPTY, TX_BELOW_TRIG, TX_SHIFT_BUSY, SLEEP_REQ;
	logic       FLOW_ENABLE, FLOW_RX_READY, MCR_RTS, MCR_DTR, line_low, w;
	logic       RX_PIN, CTS_N_PIN, DSR_N_PIN, RTS_N_PIN, DTR_N_PIN;
	logic       FLOW_CTS_OK, MODEM_CTS, MODEM_DSR, TX_ENABLE, RX_ENABLE;
	logic       MULTIDROP, SLEEPING, TX_EMPTY_IRQ, CORE_RESET;
	int         failures, samples_checked, n;
	// Rows: written value, readback, then tx enable, rx enable, mode.
	logic [18:0] rows [6] = '{{8'h00, 8'h00, 3'h6}, {8'h01, 8'h01, 3'h7},
		{8'h02, 8'h02, 3'h4}, {8'h04, 8'h04, 3'h2}, {8'hff, 8'h3f, 3'h1},
		{8'hc0, 8'h00, 3'h6}};

	ufc_feature_ctrl #(.SOFT_RESET_TRIGGER_CYCLES(SRST_CYCLES)) u_ufc_feature_ctrl (
		.CORE_CLK(CORE_CLK), .RESET(RESET), .REG_CS(REG_CS),
		.REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
		.REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .BIT_TICK(BIT_TICK),
		.TX_FIFO_EMPTY(TX_FIFO_EMPTY), .TX_BELOW_TRIG(TX_BELOW_TRIG),
		.TX_SHIFT_BUSY(TX_SHIFT_BUSY), .SLEEP_REQ(SLEEP_REQ),
		.RX_PIN(RX_PIN), .FLOW_ENABLE(FLOW_ENABLE),
		.FLOW_RX_READY(FLOW_RX_READY), .MCR_RTS(MCR_RTS),
		.MCR_DTR(MCR_DTR), .CTS_N_PIN(CTS_N_PIN), .DSR_N_PIN(DSR_N_PIN),
		.RTS_N_PIN(RTS_N_PIN), .DTR_N_PIN(DTR_N_PIN),
		.FLOW_CTS_OK(FLOW_CTS_OK), .MODEM_CTS(MODEM_CTS),
		.MODEM_DSR(MODEM_DSR), .TX_ENABLE(TX_ENABLE),
		.RX_ENABLE(RX_ENABLE), .MULTIDROP(MULTIDROP),
		.SLEEPING(SLEEPING), .TX_EMPTY_IRQ(TX_EMPTY_IRQ),
		.CORE_RESET(CORE_RESET));
	ufc_line_model u_ufc_line_model (.clk(CORE_CLK), .line_low(line_low),
		.peer_ready(peer_ready), .rx_line(RX_PIN), .cts_n(CTS_N_PIN),
		.dsr_n(DSR_N_PIN));

	// Free-running clock at 25 MHz.
	initial CORE_CLK = 1'b0;
	always #20 CORE_CLK = ~CORE_CLK;

	task automatic stop_test;
		if (failures == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(negedge CORE_CLK);
	endtask

	// Bus cycles hold for one rising edge, so back-to-back calls leave a gap.
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		cyc(1);
		{REG_CS, REG_WR, REG_ADDR, REG_WDATA} = {2'b11, a, d};
		cyc(1);
		{REG_CS, REG_WR} = 2'b00;
	endtask

	task automatic rd(input logic [1:0] a, input logic [7:0] e);
		cyc(1);
		{REG_CS, REG_RD, REG_ADDR} = {2'b11, a};
		cyc(1);
		{REG_CS, REG_RD} = 2'b00;
		chk(REG_RDATA, e);
	endtask

	task automatic tick;
		BIT_TICK = 1'b1;
		cyc(1);
		BIT_TICK = 1'b0;
		cyc(1);
	endtask

	function automatic logic dpin(input logic sel);
		return sel ? DTR_N_PIN : RTS_N_PIN;
	endfunction

	// Watchdog well past the two hundred or so cycles the sequence needs.
	initial begin
		cyc(4000);
		failures++;
		stop_test;
	end

	// Main sequence.
	initial begin
		{RESET, REG_CS, REG_WR, REG_RD, BIT_TICK, REG_ADDR} = 7'h40;
		{REG_WDATA, peer_ready, line_low} = '0;
		{TX_FIFO_EMPTY, TX_BELOW_TRIG, TX_SHIFT_BUSY, SLEEP_REQ} = 4'h8;
		{FLOW_ENABLE, FLOW_RX_READY, MCR_RTS, MCR_DTR} = 4'h0;
		cyc(3);
		RESET = 1'b0;
		chk({TX_ENABLE, RX_ENABLE, MULTIDROP, CORE_RESET, RTS_N_PIN,
			DTR_N_PIN, SLEEPING, TX_EMPTY_IRQ}, 8'hcc);
		rd(LINE_FC_ADDR, LFC_RESET);
		rd(MISC_FC_ADDR, MFC_RESET);
		for (int i = 0; i < 6; i++) begin
			wr(LINE_FC_ADDR, rows[i][18:11]);
			rd(LINE_FC_ADDR, rows[i][10:3]);
			chk({TX_ENABLE, RX_ENABLE, MULTIDROP}, rows[i][2:0]);
		end
		wr(MISC_FC_ADDR, 8'he9);
		rd(MISC_FC_ADDR, 8'h01);
		wr(2'h3, 8'hff);
		rd(2'h3, 8'h00);
		// Transmit-empty modes with the shift register busy and idle.
		TX_SHIFT_BUSY = 1'b1;
		cyc(2);
		chk(TX_EMPTY_IRQ, 1'b0);
		TX_SHIFT_BUSY = 1'b0;
		cyc(2);
		chk(TX_EMPTY_IRQ, 1'b1);
		wr(MISC_FC_ADDR, 8'h00);
		TX_SHIFT_BUSY = 1'b1;
		cyc(2);
		chk(TX_EMPTY_IRQ, 1'b1);
		{TX_FIFO_EMPTY, TX_BELOW_TRIG, TX_SHIFT_BUSY} = 3'b010;
		cyc(2);
		chk(TX_EMPTY_IRQ, 1'b1);
		TX_BELOW_TRIG = 1'b0;
		cyc(2);
		chk(TX_EMPTY_IRQ, 1'b0);
		TX_FIFO_EMPTY = 1'b1;
		// Direction pin for every pin choice and polarity, two-bit turnaround.
		wr(TURN_DLY_ADDR, 8'h02);
		for (int i = 0; i < 4; i++) begin
			wr(LINE_FC_ADDR, {2'b00, i[1], 1'b1, i[0], 3'b001});
			TX_FIFO_EMPTY = 1'b0;
			cyc(4);
			chk(dpin(i[0]), i[1]);
			chk(dpin(!i[0]), 1'b1);
			TX_FIFO_EMPTY = 1'b1;
			cyc(2);
			tick;
			chk(dpin(i[0]), i[1]);
			tick;
			cyc(3);
			chk(dpin(i[0]), !i[1]);
		end
		for (int j = 0; j < 2; j++) begin
			wr(LINE_FC_ADDR, j ? 8'h10 : 8'h01);
			TX_FIFO_EMPTY = 1'b0;
			cyc(4);
			chk(RTS_N_PIN, 1'b1);
			TX_FIFO_EMPTY = 1'b1;
		end
		// Flow control on its own pair and moved to the second pair.
		wr(LINE_FC_ADDR, 8'h00);
		{FLOW_ENABLE, FLOW_RX_READY, peer_ready} = 4'hd;
		cyc(5);
		chk({RTS_N_PIN, DTR_N_PIN, FLOW_CTS_OK, MODEM_CTS, MODEM_DSR}, 5'h0e);
		wr(MISC_FC_ADDR, 8'h04);
		cyc(5);
		chk({RTS_N_PIN, DTR_N_PIN, FLOW_CTS_OK, MODEM_CTS, MODEM_DSR}, 5'h12);
		{MCR_RTS, peer_ready} = 3'h6;
		cyc(5);
		chk({RTS_N_PIN, DTR_N_PIN, FLOW_CTS_OK, MODEM_CTS, MODEM_DSR}, 5'h05);
		{FLOW_ENABLE, MCR_RTS} = 2'b00;
		// Sleep with level wake, then with edge wake.
		wr(MISC_FC_ADDR, 8'h00);
		// Let the low line pass the synchroniser before asking to sleep,
		// and watch every cycle: a brief sleep would also be a failure.
		line_low = 1'b1;
		cyc(4);
		SLEEP_REQ = 1'b1;
		w = 1'b0;
		repeat (6) begin
			cyc(1);
			w |= SLEEPING;
		end
		chk(w, 1'b0);
		line_low = 1'b0;
		cyc(6);
		chk(SLEEPING, 1'b1);
		line_low = 1'b1;
		cyc(5);
		chk(SLEEPING, 1'b0);
		wr(MISC_FC_ADDR, 8'h10);
		cyc(6);
		chk(SLEEPING, 1'b1);
		line_low = 1'b0;
		w = 1'b0;
		repeat (6) begin
			cyc(1);
			w |= !SLEEPING;
		end
		chk(w, 1'b1);
		SLEEP_REQ = 1'b0;
		// Soft reset with a write landing inside the count.
		wr(LINE_FC_ADDR, 8'h3f);
		wr(MISC_FC_ADDR, 8'h02);
		wr(LINE_FC_ADDR, 8'h21);
		n = 2;
		while (CORE_RESET === 1'b1 && n < 9) begin
			n++;
			cyc(1);
		end
		chk(n[7:0], 8'(SRST_CYCLES));
		rd(LINE_FC_ADDR, LFC_RESET);
		rd(MISC_FC_ADDR, MFC_RESET);
		chk({TX_ENABLE, RX_ENABLE, MULTIDROP}, 3'h6);
		stop_test;
	end
endmodule
`default_nettype wire
